// ### test_udcc_top.sv
// Self-checking bench for the up/down counter control block
`include "udcc_consts.svh"
`default_nettype none
module test_udcc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata_ff;
  logic [2:0] pins;
  logic [15:0] compare_reg_zero = 16'h1234;
  logic [15:0] compare_reg_one = 16'h5555;
  logic [15:0] cnt, capcmp_chan_zero_ff, capcmp_chan_one_ff, mx, st;
  logic [7:0] port5_direction_ff;
  logic [7:0] tmc_ff = 8'h00;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int hold = 12;
  logic [15:0] ra [9] = '{`UDCC_ADDR_PORT5_DIR, `UDCC_ADDR_PRM,
    `UDCC_ADDR_STS, `UDCC_ADDR_CCR, `UDCC_ADDR_TUM, `UDCC_ADDR_SESA_LO,
    `UDCC_ADDR_SESA_HI, `UDCC_ADDR_NRC, `UDCC_ADDR_TMC};
  logic [7:0] rv [9] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic [7:0] rm [9] = '{8'hFF, 8'h07, 8'h00, 8'h03, 8'h8D, 8'hFF, 8'h03,
    8'h03, 8'h4F};

  udcc_top dut (.clk_sys, .rst, .addr, .wr_en, .rd_en, .wdata, .rdata_ff,
    .count_pulse_pin(pins[0]), .direction_pin(pins[1]),
    .ext_clear_pin(pins[2]), .compare_reg_zero, .compare_reg_one,
    .updown_count_value_ff(cnt), .capcmp_chan_zero_ff, .capcmp_chan_one_ff,
    .port5_direction_ff);
  udcc_pin_src src (.clk_sys, .pins);

  // Free-running clock
  initial forever #50 clk_sys = ~clk_sys;

  // Report the counts and the verdict, then stop
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cut a hung run short
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      close_out();
    end
  end

  // Compare one value and record any mismatch
  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Register write and read cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk("register", {8'h00, rdata_ff}, {8'h00, e});
  endtask
  task automatic rd_sts2(input logic [7:0] e1, input logic [7:0] e2);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= `UDCC_ADDR_STS;
    @(posedge clk_sys);
    #1 chk("status", {8'h00, rdata_ff}, {8'h00, e1});
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk("status", {8'h00, rdata_ff}, {8'h00, e2});
  endtask

  // Stop counting before any other control bit changes
  task automatic tmc(input logic [7:0] d);
    wr(`UDCC_ADDR_TMC, tmc_ff & 8'h0F);
    wr(`UDCC_ADDR_TMC, d & 8'h0F);
    wr(`UDCC_ADDR_TMC, d);
    tmc_ff = d;
  endtask
  task automatic pulse(input int i);
    src.tog(i, hold);
    src.tog(i, hold);
  endtask
  task automatic ck(input logic [15:0] e);
    chk("count", cnt, e);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values and writable bits of every register
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (ra[i]) wr(ra[i], 8'hFF);
    foreach (ra[i]) rd(ra[i], rm[i]);
    tmc_ff = 8'h4F;
    tmc(8'h00);
    foreach (ra[i]) wr(ra[i], 8'h00);
    rd(16'h1000, 8'h00);
    wr(`UDCC_ADDR_PORT5_DIR, 8'hE0);
    #1 chk("port", {8'h00, port5_direction_ff}, 16'h00E0);
    // General mode: match clear, free run, prescaler codes 1 to 7
    wr(`UDCC_ADDR_NRC, 8'h03);
    compare_reg_zero <= 16'h0003;
    wr(`UDCC_ADDR_PRM, 8'h01);
    tmc(8'h44);
    mx = 16'h0000;
    repeat (64)
    begin
      @(posedge clk_sys);
      #1 if (cnt > mx) mx = cnt;
    end
    chk("max", mx, 16'h0003);
    tmc(8'h40);
    repeat (64) @(posedge clk_sys);
    chk("free", 16'(cnt > 16'h0003), 16'h0001);
    for (int c = 1; c < 8; c++)
    begin
      tmc(8'h00);
      wr(`UDCC_ADDR_PRM, 8'(c));
      tmc(8'h40);
      mx = cnt;
      repeat (256) @(posedge clk_sys);
      st = cnt - mx;
      chk("rate", 16'(st + 1 >= 16'(256 >> c) && st <= 16'(256 >> c) + 1),
        16'h0001);
    end
    // Capture zero takes the running count on a falling edge
    pulse(1);
    chk("cap0", 16'(capcmp_chan_zero_ff == cnt
      || capcmp_chan_zero_ff + 16'h0001 == cnt), 16'h0001);
    tmc(8'h00);
    mx = cnt;
    repeat (20) @(posedge clk_sys);
    ck(mx);
    rd(`UDCC_ADDR_STS, 8'h00);
    // Second reset, then up/down counting in the compare-bounded submode
    @(posedge clk_sys) rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    tmc_ff = 8'h00;
    compare_reg_zero <= 16'h1234;
    wr(`UDCC_ADDR_NRC, 8'h03);
    wr(`UDCC_ADDR_SESA_LO, 8'h50);
    wr(`UDCC_ADDR_SESA_HI, 8'h01);
    wr(`UDCC_ADDR_PRM, 8'h04);
    wr(`UDCC_ADDR_TUM, 8'h81);
    tmc(8'h48);
    src.tog(1, hold);
    pulse(0);
    ck(16'hFFFF);
    src.tog(1, hold);
    pulse(0);
    ck(16'h0000);
    rd_sts2(8'h06, 8'h00);
    pulse(0);
    pulse(2);
    ck(16'h0001);
    chk("cap1", capcmp_chan_one_ff, 16'h0001);
    pulse(1);
    chk("cap0", capcmp_chan_zero_ff, 16'h0000);
    tmc(8'h08);
    wr(`UDCC_ADDR_CCR, 8'h02);
    tmc(8'h48);
    pulse(0);
    pulse(2);
    chk("cap1", capcmp_chan_one_ff, 16'h0001);
    // Clear-by-select submode: reload, clear pin, clear sources
    tmc(8'h00);
    wr(`UDCC_ADDR_CCR, 8'h00);
    wr(`UDCC_ADDR_TUM, 8'h80);
    tmc(8'h48);
    src.tog(1, hold);
    repeat (3) pulse(0);
    ck(16'h1234);
    rd(`UDCC_ADDR_STS, 8'h05);
    tmc(8'h08);
    pulse(2);
    ck(16'h0000);
    pulse(0);
    ck(16'h0000);
    src.tog(1, hold);
    compare_reg_zero <= 16'h0002;
    // Match-clear enable stays set: up/down mode must ignore it
    for (int s = 0; s < 4; s++)
    begin
      tmc(8'h44 | 8'(s));
      repeat (3) pulse(0);
      ck((s == 1 || s == 2) ? 16'h0000 : 16'h0003);
      pulse(2);
      ck(s < 3 ? 16'h0000 : 16'h0003);
    end
    tmc(8'h41);
    src.tog(1, hold);
    repeat (2) pulse(0);
    ck(16'h0001);
    src.tog(1, hold);
    // One step up and back down in decoding modes 1 to 3, two steps in mode 4
    for (int m = 4; m < 8; m++)
    begin
      tmc(8'h00);
      wr(`UDCC_ADDR_PRM, 8'(m));
      tmc(8'h43);
      mx = cnt;
      st = (m == 7) ? 16'h0002 : 16'h0001;
      if (m == 7)
      begin
        src.tog(0, hold);
        src.tog(1, hold);
      end
      else
        pulse(0);
      ck(mx + st);
      if (m == 7)
      begin
        src.tog(1, hold);
        src.tog(0, hold);
      end
      else if (m == 5)
        pulse(1);
      else
      begin
        src.tog(1, hold);
        pulse(0);
        src.tog(1, hold);
      end
      ck(mx);
    end
    // Short pulse rejected, long pulse kept, at every sampling rate
    tmc(8'h00);
    wr(`UDCC_ADDR_PRM, 8'h04);
    for (int n = 0; n < 4; n++)
    begin
      tmc(8'h00);
      wr(`UDCC_ADDR_NRC, 8'(n));
      tmc(8'h43);
      mx = cnt;
      hold = 3 * (8 >> n);
      pulse(0);
      hold = 7 * (8 >> n) + 4;
      pulse(0);
      ck(mx + 16'h0001);
    end
    close_out();
  end
endmodule
`default_nettype wire

// ### udcc_consts.svh
// Register offsets, field positions, reset values and counts of the counter
`ifndef UDCC_CONSTS_SVH
`define UDCC_CONSTS_SVH

// Register addresses
`define UDCC_ADDR_PORT5_DIR 16'hFF25
`define UDCC_ADDR_PRM 16'hFF3A
`define UDCC_ADDR_STS 16'hFF3B
`define UDCC_ADDR_CCR 16'hFF94
`define UDCC_ADDR_TUM 16'hFF95
`define UDCC_ADDR_TMC 16'hFF96
`define UDCC_ADDR_SESA_LO 16'hFF97
`define UDCC_ADDR_SESA_HI 16'hFF98
`define UDCC_ADDR_NRC 16'hFFAA

// Reset values
`define UDCC_RST_PORT5_DIR 8'hFF
`define UDCC_RST_PRM 8'h07
`define UDCC_RST_ZERO 8'h00

// Readable bits of each register
`define UDCC_MASK_PRM 8'h07
`define UDCC_MASK_CCR 8'h03
`define UDCC_MASK_TUM 8'h8D
`define UDCC_MASK_TMC 8'h4F
`define UDCC_MASK_SESA_HI 8'h03
`define UDCC_MASK_NRC 8'h03

// Field positions
`define UDCC_TUM_CMD 7
`define UDCC_TUM_MSEL 0
`define UDCC_TMC_CE 6
`define UDCC_TMC_RLEN 3
`define UDCC_TMC_ENMD 2
`define UDCC_CCR_CMS0 0
`define UDCC_CCR_CMS1 1
`define UDCC_STS_UDF 2
`define UDCC_STS_OVF 1
`define UDCC_STS_UBD 0

// Decoding mode codes of the prescaler field
`define UDCC_PRM_MODE1 3'h4
`define UDCC_PRM_MODE2 3'h5
`define UDCC_PRM_MODE3 3'h6
`define UDCC_PRM_MODE4 3'h7

// Consecutive equal samples the filter needs
`define UDCC_FILTER_SAMPLES 5

`endif

// ### udcc_noise_filter.sv
// Synchroniser and five-sample digital noise filter for one counter pin
`include "udcc_consts.svh"
`default_nettype none
module udcc_noise_filter #(
  parameter int SAMPLES = `UDCC_FILTER_SAMPLES
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, active high
  udcc_pin_if.filt pin // Raw pin in, filtered level and edges out
);

  // Refuse a filter too short to reject anything
  if (SAMPLES < 2)
  begin : g_chk
    $error("udcc_noise_filter: SAMPLES must be at least 2");
  end

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [SAMPLES-1:0] hist;
    logic level;
    logic rise;
    logic fall;
  } udcc_filt_s;

  udcc_filt_s s_ff;
  udcc_filt_s nxt_s;

  // Two-stage synchroniser, sample history and accepted level
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.sync1 = pin.raw;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.rise = 1'b0;
    nxt_s.fall = 1'b0;
    if (pin.sample_tick)
    begin
      nxt_s.hist = {s_ff.hist[SAMPLES-2:0], s_ff.sync2};
      if (&nxt_s.hist && !s_ff.level)
      begin
        nxt_s.level = 1'b1;
        nxt_s.rise = 1'b1;
      end
      else if (~|nxt_s.hist && s_ff.level)
      begin
        nxt_s.level = 1'b0;
        nxt_s.fall = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // Filtered outputs
  assign pin.level = s_ff.level;
  assign pin.rise = s_ff.rise;
  assign pin.fall = s_ff.fall;

endmodule
`default_nettype wire

// ### udcc_pin_if.sv
// Link between one noise filter and the counter control
`default_nettype none
interface udcc_pin_if;
  logic raw;
  logic sample_tick;
  logic level;
  logic rise;
  logic fall;

  modport filt (input raw, input sample_tick, output level, output rise,
    output fall);
  modport user (output raw, output sample_tick, input level, input rise,
    input fall);
endinterface
`default_nettype wire

// ### udcc_pin_src.sv
// Pulse and encoder source model for the counter input pins
`default_nettype none
module udcc_pin_src (
  input wire logic clk_sys, // System clock
  output var logic [2:0] pins // Pulse, direction and clear pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Flip one pin, then hold the level for hold clock cycles
  task automatic tog(input int i, input int hold);
    @(posedge clk_sys);
    pins[i] <= ~pins[i];
    repeat (hold) @(posedge clk_sys);
  endtask
  initial pins = 3'h0;
endmodule
`default_nettype wire

// ### udcc_pkg.sv
// Types shared by the counter control modules
`default_nettype none
package udcc_pkg;

  // Valid edge selection per counter input function
  typedef enum logic [1:0] {
    UDCC_EDGE_FALL = 2'h0,
    UDCC_EDGE_RISE = 2'h1,
    UDCC_EDGE_BOTH = 2'h2,
    UDCC_EDGE_BOTH_ALT = 2'h3
  } udcc_edge_e;

  // Clear source selection in the clear-by-select submode
  typedef enum logic [1:0] {
    UDCC_CLR_PIN = 2'h0,
    UDCC_CLR_MATCH = 2'h1,
    UDCC_CLR_EITHER = 2'h2,
    UDCC_CLR_NONE = 2'h3
  } udcc_clr_e;

endpackage
`default_nettype wire

// ### udcc_top.sv
// Up/down counter control, status and pin filtering
`include "udcc_consts.svh"
`default_nettype none
module udcc_top #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [15:0] addr, // Register address
  input wire logic wr_en, // Register write strobe
  input wire logic rd_en, // Register read strobe
  input wire logic [7:0] wdata, // Register write data
  output logic [7:0] rdata_ff, // Register read data, one cycle later
  input wire logic count_pulse_pin, // Count pulse input
  input wire logic direction_pin, // Direction input, also capture zero
  input wire logic ext_clear_pin, // Clear input, also capture one
  input wire logic [WIDTH-1:0] compare_reg_zero, // Compare register zero
  input wire logic [WIDTH-1:0] compare_reg_one, // Compare register one
  output logic [WIDTH-1:0] updown_count_value_ff, // Counter value
  output logic [WIDTH-1:0] capcmp_chan_zero_ff, // Channel zero capture
  output logic [WIDTH-1:0] capcmp_chan_one_ff, // Channel one capture
  output logic [7:0] port5_direction_ff // Port direction bits
);

  // Refuse counter widths the logic cannot serve
  if (WIDTH < 2)
  begin : g_chk
    $error("udcc_top: WIDTH must be at least 2");
  end

  localparam int NPIN = 3;
  localparam logic [WIDTH-1:0] CNT_MAX = '1;

  typedef struct packed {
    logic [7:0] port5_dir;
    logic [7:0] prm;
    logic [7:0] ccr;
    logic [7:0] tum;
    logic [7:0] tmc;
    logic [7:0] sesa_lo;
    logic [7:0] sesa_hi;
    logic [7:0] nrc;
    logic udf;
    logic ovf;
    logic ubd;
    logic [6:0] div;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] cap0;
    logic [WIDTH-1:0] cap1;
    logic [7:0] rdata;
  } udcc_top_s;

  udcc_top_s s_ff;
  udcc_top_s nxt_s;
  udcc_top_s rst_s;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic sample_tick;

  // Pin order: 0 count pulse, 1 direction, 2 clear
  assign pin_raw = {ext_clear_pin, direction_pin, count_pulse_pin};

  // One filter per physical pin
  for (genvar i = 0; i < NPIN; i++)
  begin : g_pin
    udcc_pin_if pif ();
    assign pif.raw = pin_raw[i];
    assign pif.sample_tick = sample_tick;
    assign lvl[i] = pif.level;
    assign rise[i] = pif.rise;
    assign fall[i] = pif.fall;
    udcc_noise_filter #(.SAMPLES(`UDCC_FILTER_SAMPLES)) u_filt (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(pif.filt)
    );
  end

  // Valid edge test for one input function
  function automatic logic edge_ok(input logic [1:0] sel, input logic r,
    input logic f);
    udcc_pkg::udcc_edge_e e;
    e = udcc_pkg::udcc_edge_e'(sel);
    unique case (e)
      udcc_pkg::UDCC_EDGE_FALL: edge_ok = f;
      udcc_pkg::UDCC_EDGE_RISE: edge_ok = r;
      udcc_pkg::UDCC_EDGE_BOTH: edge_ok = r | f;
      udcc_pkg::UDCC_EDGE_BOTH_ALT: edge_ok = r | f;
    endcase
  endfunction

  // Reset image of the whole state
  always_comb
  begin
    rst_s = '0;
    rst_s.port5_dir = `UDCC_RST_PORT5_DIR;
    rst_s.prm = `UDCC_RST_PRM;
    rst_s.ccr = `UDCC_RST_ZERO;
    rst_s.tum = `UDCC_RST_ZERO;
    rst_s.tmc = `UDCC_RST_ZERO;
    rst_s.sesa_lo = `UDCC_RST_ZERO;
    rst_s.sesa_hi = `UDCC_RST_ZERO;
    rst_s.nrc = `UDCC_RST_ZERO;
  end

  // Mode decoding
  logic udc_mode;
  logic clear_by_select;
  logic compare_bounded;
  logic cnt_en;
  udcc_pkg::udcc_clr_e clr_sel;
  assign udc_mode = s_ff.tum[`UDCC_TUM_CMD];
  assign clear_by_select = udc_mode & ~s_ff.tum[`UDCC_TUM_MSEL];
  assign compare_bounded = udc_mode & s_ff.tum[`UDCC_TUM_MSEL];
  assign cnt_en = s_ff.tmc[`UDCC_TMC_CE];
  assign clr_sel = udcc_pkg::udcc_clr_e'(s_ff.tmc[1:0]);

  // Shared divider: prescaler tick and filter sampling tick
  logic [6:0] pre_mask;
  logic [2:0] smp_mask;
  logic pre_tick;
  always_comb
  begin
    pre_mask = 7'((8'h01 << s_ff.prm[2:0]) - 8'h01);
    unique case (s_ff.nrc[1:0])
      2'h0: smp_mask = 3'h7;
      2'h1: smp_mask = 3'h3;
      2'h2: smp_mask = 3'h1;
      2'h3: smp_mask = 3'h0;
    endcase
    pre_tick = (s_ff.div & pre_mask) == pre_mask;
    sample_tick = (s_ff.div[2:0] & smp_mask) == smp_mask;
  end

  // Valid edges of the five input functions
  logic ev_iud;
  logic ev_cud;
  logic ev_cc0;
  logic ev_cc1;
  logic ev_clr;
  always_comb
  begin
    ev_iud = edge_ok(s_ff.sesa_lo[5:4], rise[0], fall[0]);
    ev_cud = edge_ok(s_ff.sesa_lo[7:6], rise[1], fall[1]);
    ev_cc0 = edge_ok(s_ff.sesa_lo[1:0], rise[1], fall[1]);
    ev_cc1 = edge_ok(s_ff.sesa_lo[3:2], rise[2], fall[2]);
    ev_clr = edge_ok(s_ff.sesa_hi[1:0], rise[2], fall[2]);
  end

  // Count step decoding per mode
  logic step_up;
  logic step_dn;
  logic qa_edge;
  logic qb_edge;
  always_comb
  begin
    step_up = 1'b0;
    step_dn = 1'b0;
    qa_edge = rise[0] | fall[0];
    qb_edge = rise[1] | fall[1];
    if (!udc_mode)
      step_up = pre_tick;
    else
    begin
      unique case (s_ff.prm[2:0])
        `UDCC_PRM_MODE1, `UDCC_PRM_MODE3:
        begin
          step_up = ev_iud & ~lvl[1];
          step_dn = ev_iud & lvl[1];
        end
        `UDCC_PRM_MODE2:
        begin
          step_up = ev_iud & ~ev_cud;
          step_dn = ev_cud & ~ev_iud;
        end
        `UDCC_PRM_MODE4:
        begin
          // Phase decides direction; edge selects play no part
          if (qa_edge && !qb_edge)
          begin
            step_up = lvl[0] != lvl[1];
            step_dn = lvl[0] == lvl[1];
          end
          else if (qb_edge && !qa_edge)
          begin
            step_up = lvl[1] == lvl[0];
            step_dn = lvl[1] != lvl[0];
          end
        end
        default: step_up = 1'b0;
      endcase
    end
    step_up = step_up & cnt_en;
    step_dn = step_dn & cnt_en;
  end

  // Clear sources
  logic match0;
  logic match1;
  logic pin_clear;
  logic match_clear_up;
  always_comb
  begin
    match0 = s_ff.count == compare_reg_zero;
    match1 = s_ff.count == compare_reg_one;
    // Clear pin acts even with counting disabled
    pin_clear = clear_by_select & ev_clr
      & (clr_sel == udcc_pkg::UDCC_CLR_PIN
      || clr_sel == udcc_pkg::UDCC_CLR_EITHER);
    if (!udc_mode)
      match_clear_up = s_ff.tmc[`UDCC_TMC_ENMD] & match0;
    else if (compare_bounded)
      match_clear_up = match0;
    else
      match_clear_up = match0
        & (clr_sel == udcc_pkg::UDCC_CLR_MATCH
        || clr_sel == udcc_pkg::UDCC_CLR_EITHER);
  end

  // Capture permission per channel
  logic cap0_ok;
  logic cap1_ok;
  assign cap0_ok = cnt_en & ~s_ff.ccr[`UDCC_CCR_CMS0]
    & ~udc_mode;
  assign cap1_ok = cnt_en & ~s_ff.ccr[`UDCC_CCR_CMS1]
    & ~clear_by_select;

  // Register read mux
  logic [7:0] rd_val;
  logic sts_rd;
  always_comb
  begin
    sts_rd = rd_en && addr == `UDCC_ADDR_STS;
    unique case (addr)
      `UDCC_ADDR_PORT5_DIR: rd_val = s_ff.port5_dir;
      `UDCC_ADDR_PRM: rd_val = s_ff.prm & `UDCC_MASK_PRM;
      `UDCC_ADDR_STS: rd_val = {5'h00, s_ff.udf, s_ff.ovf, s_ff.ubd};
      `UDCC_ADDR_CCR: rd_val = s_ff.ccr & `UDCC_MASK_CCR;
      `UDCC_ADDR_TUM: rd_val = s_ff.tum & `UDCC_MASK_TUM;
      `UDCC_ADDR_TMC: rd_val = s_ff.tmc & `UDCC_MASK_TMC;
      `UDCC_ADDR_SESA_LO: rd_val = s_ff.sesa_lo;
      `UDCC_ADDR_SESA_HI: rd_val = s_ff.sesa_hi & `UDCC_MASK_SESA_HI;
      `UDCC_ADDR_NRC: rd_val = s_ff.nrc & `UDCC_MASK_NRC;
      default: rd_val = 8'h00;
    endcase
  end

  // Next state: registers, counter, flags, captures
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.div = 7'(s_ff.div + 7'h01);
    nxt_s.rdata = rd_en ? rd_val : s_ff.rdata;
    // Software writes; status is read-only
    if (wr_en)
    begin
      unique case (addr)
        `UDCC_ADDR_PORT5_DIR: nxt_s.port5_dir = wdata;
        `UDCC_ADDR_PRM: nxt_s.prm = wdata & `UDCC_MASK_PRM;
        `UDCC_ADDR_CCR: nxt_s.ccr = wdata & `UDCC_MASK_CCR;
        `UDCC_ADDR_TUM: nxt_s.tum = wdata & `UDCC_MASK_TUM;
        `UDCC_ADDR_TMC: nxt_s.tmc = wdata & `UDCC_MASK_TMC;
        `UDCC_ADDR_SESA_LO: nxt_s.sesa_lo = wdata;
        `UDCC_ADDR_SESA_HI: nxt_s.sesa_hi = wdata & `UDCC_MASK_SESA_HI;
        `UDCC_ADDR_NRC: nxt_s.nrc = wdata & `UDCC_MASK_NRC;
        default: nxt_s.nrc = nxt_s.nrc;
      endcase
    end
    // Status read clears the underflow and overflow flags; a new event below still sets them
    if (sts_rd)
    begin
      nxt_s.udf = 1'b0;
      nxt_s.ovf = 1'b0;
    end
    // Counter update, clear pin first
    if (pin_clear)
      nxt_s.count = '0;
    else if (step_up)
    begin
      if (match_clear_up)
        nxt_s.count = '0;
      else if (s_ff.count == CNT_MAX)
      begin
        nxt_s.count = '0;
        nxt_s.ovf = 1'b1;
      end
      else
        nxt_s.count = WIDTH'(s_ff.count + 1'b1);
      nxt_s.ubd = 1'b0;
    end
    else if (step_dn)
    begin
      if (compare_bounded && match1)
        nxt_s.count = '0;
      else if (s_ff.count == '0)
      begin
        nxt_s.udf = 1'b1;
        if (clear_by_select && s_ff.tmc[`UDCC_TMC_RLEN])
          nxt_s.count = compare_reg_zero;
        else
          nxt_s.count = CNT_MAX;
      end
      else
        nxt_s.count = WIDTH'(s_ff.count - 1'b1);
      nxt_s.ubd = 1'b1;
    end
    if (!udc_mode)
      nxt_s.ubd = 1'b0;

    // Captures of the count on valid trigger edges
    if (cap0_ok && ev_cc0)
      nxt_s.cap0 = s_ff.count;
    if (cap1_ok && ev_cc1)
      nxt_s.cap1 = s_ff.count;
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s_ff <= rst_s;
    else
      s_ff <= nxt_s;
  end

  // Outputs straight from the state register
  assign rdata_ff = s_ff.rdata;
  assign updown_count_value_ff = s_ff.count;
  assign capcmp_chan_zero_ff = s_ff.cap0;
  assign capcmp_chan_one_ff = s_ff.cap1;
  assign port5_direction_ff = s_ff.port5_dir;

endmodule
`default_nettype wire

// ### udcc_top_props.sv
// Port-level assertions for the up/down counter control block
`include "udcc_consts.svh"
`default_nettype none
module udcc_top_props #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [15:0] addr, // Register address
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic [7:0] wdata, // Write data
  input wire logic [7:0] rdata_ff, // Read data
  input wire logic [WIDTH-1:0] compare_reg_zero, // Reload source
  input wire logic [WIDTH-1:0] updown_count_value_ff, // Counter
  input wire logic [WIDTH-1:0] capcmp_chan_zero_ff, // Capture zero
  input wire logic [WIDTH-1:0] capcmp_chan_one_ff, // Capture one
  input wire logic [7:0] port5_direction_ff // Port direction bits
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Read port and register fields
  a_rdata_hold: assert property (!rd_en |=> $stable(rdata_ff))
    else $error("read data moved without a read");
  a_status_zero: assert property (rd_en && addr == `UDCC_ADDR_STS
    |=> rdata_ff[7:3] == 5'h00) else $error("status reserved bits set");
  a_read_clears: assert property ((rd_en && addr == `UDCC_ADDR_STS) ##1
    (rd_en && addr == `UDCC_ADDR_STS && $stable(updown_count_value_ff))
    |=> rdata_ff[2:1] == 2'h0) else $error("flags kept after a read");
  a_ccr_field: assert property (rd_en && addr == `UDCC_ADDR_CCR
    |-> ##1 rdata_ff[7:2] == 6'h00) else $error("mode register bits wrong");
  a_prm_field: assert property (rd_en && addr == `UDCC_ADDR_PRM
    |=> rdata_ff[7:3] == 5'h00) else $error("prescaler bits wrong");
  a_port_write: assert property (wr_en && addr == `UDCC_ADDR_PORT5_DIR
    |=> port5_direction_ff == $past(wdata)) else $error("port write lost");
  // Counter moves by one step, a clear or a reload only
  a_count_step: assert property ($changed(updown_count_value_ff) |->
    updown_count_value_ff == $past(updown_count_value_ff) + 1'b1 ||
    updown_count_value_ff == $past(updown_count_value_ff) - 1'b1 ||
    updown_count_value_ff == '0 ||
    updown_count_value_ff == $past(compare_reg_zero))
    else $error("counter jumped");
  // Captures take the counter value
  a_cap_zero: assert property ($changed(capcmp_chan_zero_ff) |->
    capcmp_chan_zero_ff == $past(updown_count_value_ff))
    else $error("capture zero value wrong");
  a_cap_one: assert property ($changed(capcmp_chan_one_ff) |->
    capcmp_chan_one_ff == $past(updown_count_value_ff))
    else $error("capture one value wrong");
endmodule
bind udcc_top udcc_top_props #(.WIDTH(WIDTH)) u_props (.clk_sys, .rst,
  .addr, .wr_en, .rd_en, .wdata, .rdata_ff, .compare_reg_zero,
  .updown_count_value_ff, .capcmp_chan_zero_ff, .capcmp_chan_one_ff,
  .port5_direction_ff);
`default_nettype wire
